// ---- logic/scf_pkg.sv ----
// Constants, field layouts and helpers for the serial channel setting block.
// Assumes one clock domain; pins are synchronised in the block.
package scf_pkg;

    localparam int CH_NUM = 2;
    localparam int ADDR_W = 20;
    localparam int PIN_W = 2 * CH_NUM;

    // Setting register addresses
    localparam logic [ADDR_W-1:0] ADDR_SET_CH0 = 20'hF0118;
    localparam logic [ADDR_W-1:0] ADDR_SET_CH1 = 20'hF011A;

    localparam logic [15:0] SET_RESET = 16'h0087;
    // Writable bits; channel 1 lacks the upper stop bit
    localparam logic [15:0] WMASK_CH0 = 16'hF7B3;
    localparam logic [15:0] WMASK_CH1 = 16'hF793;
    localparam logic [15:0] FIXED_ONES = 16'h0004;
    localparam logic [15:0] READ_NONE = 16'h0000;

    localparam logic [1:0] MODE_CLOCKED = 2'h0;
    localparam logic [1:0] MODE_ASYNC = 2'h1;
    localparam logic [1:0] MODE_TWOWIRE = 2'h2;

    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD = 2'h3;

    localparam logic [1:0] STOP_NONE = 2'h0;
    localparam logic [1:0] STOP_ONE = 2'h1;
    localparam logic [1:0] STOP_TWO = 2'h2;
    localparam logic [1:0] STOP_BAD = 2'h3;

    localparam logic [1:0] LEN_9 = 2'h1;
    localparam logic [1:0] LEN_7 = 2'h2;
    localparam logic [1:0] LEN_8 = 2'h3;
    localparam logic [3:0] BITS_7 = 4'h7;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;
    localparam logic [3:0] BIT_STEP = 4'h1;
    localparam logic [8:0] WORD_ALL = 9'h1FF;

    localparam logic LINE_IDLE = 1'b1;
    localparam logic LINE_START = 1'b0;

    typedef struct packed {
        logic txEnable;
        logic rxEnable;
        logic dataPhase;
        logic clockPolarity;
        logic zeroB11;
        logic errIrqSelect;
        logic [1:0] parity;
        logic bitOrder;
        logic zeroB6;
        logic [1:0] stop;
        logic zeroB3;
        logic oneB2;
        logic [1:0] length;
    } scf_setting_s;

    typedef struct packed {
        logic running;
        logic modeHigh;
        logic modeLow;
        logic irqSource;
        logic bitTick;
        logic txLoad;
        logic [8:0] txData;
    } scf_chan_in_s;

    typedef struct packed {
        logic txd;
        logic [8:0] rxWord;
        logic rxDoneIrq;
        logic rxErrIrq;
        logic xferIrq;
        logic parityErr;
        logic frameErr;
        logic txBusy;
    } scf_chan_out_s;

    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP, ST_DONE} scf_state_e;

    function automatic logic [3:0] lenBits(input logic [1:0] code);
        case (code)
            LEN_9: lenBits = BITS_9;
            LEN_7: lenBits = BITS_7;
            default: lenBits = BITS_8;
        endcase
    endfunction

    // Stop code equals its count; prohibited code acts as one
    function automatic logic [1:0] stopCount(input logic [1:0] code);
        stopCount = (code == STOP_BAD) ? STOP_ONE : code;
    endfunction

    // Bit order 0 sends the top bit of the word first
    function automatic logic [3:0] bitPos(input logic [3:0] idx, input logic [3:0] nbits, input logic lsbFirst);
        bitPos = lsbFirst ? idx : 4'(nbits - BIT_STEP - idx);
    endfunction

    function automatic logic parityBit(input logic [8:0] word, input logic [3:0] nbits, input logic [1:0] par);
        logic p;
        p = ^(word & ~(WORD_ALL << nbits));
        case (par)
            PAR_EVEN: parityBit = p;
            PAR_ODD: parityBit = ~p;
            default: parityBit = 1'b0;
        endcase
    endfunction

endpackage

// ---- logic/scf_sync.sv ----
// Two-stage synchroniser for the serial pins.
// Assumes pins are asynchronous to clk; only the second stage is read.
`timescale 1ns/1ps
module scf_sync (
    input wire logic clk,
    input wire logic rstLocal_b,
    input wire logic [scf_pkg::PIN_W-1:0] din,
    output logic [scf_pkg::PIN_W-1:0] dout
);
    import scf_pkg::*;

    logic [PIN_W-1:0] stage1;

    always_ff @(posedge clk or negedge rstLocal_b) begin
        if (!rstLocal_b) begin
            stage1 <= '1;
            dout <= '1;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end

endmodule

// ---- logic/scf_top.sv ----
// Setting registers and frame engines for two serial channels.
// Assumes word-wide writes and an external bit tick in async mode.
`timescale 1ns/1ps
// How it works
// - Both setting registers reset to 0087H.
// - Enable bits gate each direction.
// - Phase and polarity pick one of four clocked timings.
// - Error select steers errored words to the error interrupt.
// - Tx parity: none, zero, even or odd.
// - Rx parity: none, unchecked, even or odd checked.
// - Bit order picks which end goes first.
// - Stop field gives zero, one or two stops; two on channel 0.
// - Transfer-end interrupt follows the last stop bit.
// - Length field selects nine, seven or eight data bits.
// - Mode field picks clocked or async; two-wire mode holds both engines idle.
// - Source bit picks transfer-end or buffer-empty interrupt.
module scf_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [scf_pkg::ADDR_W-1:0] memAddr,
    input wire logic [15:0] memWdata,
    input wire logic memWrite,
    input wire logic memRead,
    output logic [15:0] memRdata,
    input wire scf_pkg::scf_chan_in_s [scf_pkg::CH_NUM-1:0] chanIn,
    input wire logic [scf_pkg::CH_NUM-1:0] serialClockPin,
    input wire logic [scf_pkg::CH_NUM-1:0] rxdPin,
    output scf_pkg::scf_chan_out_s [scf_pkg::CH_NUM-1:0] chanOut
);
    import scf_pkg::*;

    logic rstMeta;
    logic rstLocal_b;
    logic [PIN_W-1:0] pinSync;
    scf_setting_s setting [CH_NUM];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta <= 1'b0;
            rstLocal_b <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstLocal_b <= rstMeta;
        end
    end

    scf_sync pinSyncer (
        .clk(clk),
        .rstLocal_b(rstLocal_b),
        .din({serialClockPin, rxdPin}),
        .dout(pinSync)
    );

    wire logic hitCh0 = memAddr == ADDR_SET_CH0;
    wire logic hitCh1 = memAddr == ADDR_SET_CH1;
    wire logic [15:0] readMux = hitCh0 ? setting[0] : (hitCh1 ? setting[1] : READ_NONE);

    always_ff @(posedge clk or negedge rstLocal_b) begin
        if (!rstLocal_b) begin
            memRdata <= READ_NONE;
        end else if (memRead) begin
            memRdata <= readMux;
        end
    end

    for (genvar ch = 0; ch < CH_NUM; ch++) begin : chan
        localparam logic [15:0] WMASK = (ch == 0) ? WMASK_CH0 : WMASK_CH1;
        wire logic [ADDR_W-1:0] myAddr = (ch == 0) ? ADDR_SET_CH0 : ADDR_SET_CH1;
        scf_chan_in_s in;
        assign in = chanIn[ch];

        wire logic setWrite = memWrite && (memAddr == myAddr) && !in.running;
        wire logic [15:0] setNext = (memWdata & WMASK) | FIXED_ONES;

        always_ff @(posedge clk or negedge rstLocal_b) begin
            if (!rstLocal_b) begin
                setting[ch] <= SET_RESET;
            end else if (setWrite) begin
                setting[ch] <= setNext;
            end
        end

        scf_setting_s cfg;
        assign cfg = setting[ch];
        wire logic [1:0] mode = {in.modeHigh, in.modeLow};
        wire logic isAsync = mode == MODE_ASYNC;
        wire logic isClocked = mode == MODE_CLOCKED;
        wire logic txOn = in.running && cfg.txEnable && (isAsync || isClocked);
        wire logic rxOn = in.running && cfg.rxEnable && (isAsync || isClocked);
        wire logic tick = isAsync && in.bitTick;
        wire logic [3:0] nbits = lenBits(cfg.length);
        wire logic lsbFirst = cfg.bitOrder;
        wire logic [1:0] stops = stopCount(cfg.stop);

        wire logic sckNow = pinSync[CH_NUM + ch];
        wire logic rxdNow = pinSync[ch];
        logic sckPrev;
        logic rxdPrev;
        always_ff @(posedge clk or negedge rstLocal_b) begin
            if (!rstLocal_b) begin
                sckPrev <= 1'b1;
                rxdPrev <= 1'b1;
            end else begin
                sckPrev <= sckNow;
                rxdPrev <= rxdNow;
            end
        end

        wire logic sckRise = sckNow && !sckPrev;
        wire logic sckFall = !sckNow && sckPrev;
        wire logic leadEdge = cfg.clockPolarity ? sckFall : sckRise;
        wire logic trailEdge = cfg.clockPolarity ? sckRise : sckFall;
        wire logic shiftEv = isClocked && (cfg.dataPhase ? leadEdge : trailEdge);
        wire logic sampleEv = isClocked && (cfg.dataPhase ? trailEdge : leadEdge);

        // Transmit side
        scf_state_e txState;
        logic [8:0] txWord;
        logic [3:0] txPtr;
        logic [3:0] txSamp;
        logic [1:0] txStops;
        logic txd;
        logic xferIrq;
        wire logic txNextBit = txWord[bitPos(txPtr, nbits, lsbFirst)];
        wire logic txFirstBit = in.txData[bitPos('0, nbits, lsbFirst)];
        wire logic txParity = parityBit(txWord, nbits, cfg.parity);

        always_ff @(posedge clk or negedge rstLocal_b) begin
            if (!rstLocal_b) begin
                txState <= ST_IDLE;
                txWord <= '0;
                txPtr <= '0;
                txSamp <= '0;
                txStops <= '0;
                txd <= LINE_IDLE;
                xferIrq <= 1'b0;
            end else if (!txOn) begin
                txState <= ST_IDLE;
                txd <= LINE_IDLE;
                xferIrq <= 1'b0;
            end else begin
                xferIrq <= 1'b0;
                case (txState)
                    ST_IDLE: begin
                        if (in.txLoad) begin
                            txWord <= in.txData;
                            txPtr <= '0;
                            txSamp <= '0;
                            xferIrq <= in.irqSource;
                            if (isAsync) begin
                                txState <= ST_START;
                                txd <= LINE_START;
                            end else begin
                                txState <= ST_DATA;
                                if (!cfg.dataPhase) begin
                                    txd <= txFirstBit;
                                    txPtr <= BIT_STEP;
                                end
                            end
                        end
                    end
                    ST_START: begin
                        if (tick) begin
                            txd <= txWord[bitPos('0, nbits, lsbFirst)];
                            txPtr <= BIT_STEP;
                            txState <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (isClocked) begin
                            if (shiftEv && txPtr < nbits) begin
                                txd <= txNextBit;
                                txPtr <= txPtr + BIT_STEP;
                            end
                            if (sampleEv) begin
                                txSamp <= txSamp + BIT_STEP;
                                if (txSamp == nbits - BIT_STEP) begin
                                    txState <= ST_DONE;
                                end
                            end
                        end else if (tick) begin
                            if (txPtr < nbits) begin
                                txd <= txNextBit;
                                txPtr <= txPtr + BIT_STEP;
                            end else if (cfg.parity != PAR_NONE) begin
                                txd <= txParity;
                                txState <= ST_PARITY;
                            end else if (stops != STOP_NONE) begin
                                txd <= LINE_IDLE;
                                txStops <= stops;
                                txState <= ST_STOP;
                            end else begin
                                txState <= ST_DONE;
                            end
                        end
                    end
                    ST_PARITY: begin
                        if (tick) begin
                            txd <= LINE_IDLE;
                            txStops <= stops;
                            txState <= (stops != STOP_NONE) ? ST_STOP : ST_DONE;
                        end
                    end
                    ST_STOP: begin
                        if (tick) begin
                            txStops <= txStops - STOP_ONE;
                            if (txStops == STOP_ONE) begin
                                txState <= ST_DONE;
                            end
                        end
                    end
                    ST_DONE: begin
                        txd <= LINE_IDLE;
                        xferIrq <= !in.irqSource;
                        txState <= ST_IDLE;
                    end
                    default: txState <= ST_IDLE;
                endcase
            end
        end

        // Receive side
        scf_state_e rxState;
        logic [8:0] rxAcc;
        logic [3:0] rxCnt;
        logic rxPerr;
        logic rxFerr;
        logic [8:0] rxWord;
        logic rxDoneIrq;
        logic rxErrIrq;
        logic parityErr;
        logic frameErr;
        wire logic [8:0] rxAccNext = rxAcc | (9'(rxdNow) << bitPos(rxCnt, nbits, lsbFirst));
        wire logic rxLast = rxCnt == nbits - BIT_STEP;
        wire logic rxEv = isAsync ? tick : sampleEv;
        wire logic rxParityBad = (cfg.parity == PAR_EVEN || cfg.parity == PAR_ODD)
            && (rxdNow != parityBit(rxAcc, nbits, cfg.parity));
        wire logic rxErr = rxPerr || rxFerr;

        always_ff @(posedge clk or negedge rstLocal_b) begin
            if (!rstLocal_b) begin
                rxState <= ST_IDLE;
                rxAcc <= '0;
                rxCnt <= '0;
                rxPerr <= 1'b0;
                rxFerr <= 1'b0;
                rxWord <= '0;
                rxDoneIrq <= 1'b0;
                rxErrIrq <= 1'b0;
                parityErr <= 1'b0;
                frameErr <= 1'b0;
            end else if (!rxOn) begin
                rxState <= ST_IDLE;
                rxDoneIrq <= 1'b0;
                rxErrIrq <= 1'b0;
                parityErr <= 1'b0;
                frameErr <= 1'b0;
            end else begin
                rxDoneIrq <= 1'b0;
                rxErrIrq <= 1'b0;
                parityErr <= 1'b0;
                frameErr <= 1'b0;
                case (rxState)
                    ST_IDLE: begin
                        rxAcc <= '0;
                        rxCnt <= '0;
                        rxPerr <= 1'b0;
                        rxFerr <= 1'b0;
                        if ((isAsync && rxdPrev && !rxdNow) || sampleEv) begin
                            rxState <= isAsync ? ST_START : ST_DATA;
                        end
                    end
                    ST_START: begin
                        if (tick) begin
                            rxState <= (rxdNow == LINE_START) ? ST_DATA : ST_IDLE;
                        end
                    end
                    ST_DATA: begin
                        if (rxEv || (isClocked && rxCnt == '0)) begin
                            rxAcc <= rxAccNext;
                            rxCnt <= rxCnt + BIT_STEP;
                            if (rxLast) begin
                                if (isClocked) begin
                                    rxState <= ST_DONE;
                                end else if (cfg.parity != PAR_NONE) begin
                                    rxState <= ST_PARITY;
                                end else begin
                                    rxState <= (cfg.stop != STOP_NONE) ? ST_STOP : ST_DONE;
                                end
                            end
                        end
                    end
                    ST_PARITY: begin
                        if (tick) begin
                            rxPerr <= rxParityBad;
                            rxState <= (cfg.stop != STOP_NONE) ? ST_STOP : ST_DONE;
                        end
                    end
                    ST_STOP: begin
                        if (tick) begin
                            rxFerr <= rxdNow != LINE_IDLE;
                            rxState <= ST_DONE;
                        end
                    end
                    ST_DONE: begin
                        rxWord <= rxAcc;
                        parityErr <= rxPerr;
                        frameErr <= rxFerr;
                        rxErrIrq <= rxErr && cfg.errIrqSelect;
                        rxDoneIrq <= !(rxErr && cfg.errIrqSelect);
                        rxState <= ST_IDLE;
                    end
                    default: rxState <= ST_IDLE;
                endcase
            end
        end

        assign chanOut[ch] = {txd, rxWord, rxDoneIrq, rxErrIrq, xferIrq, parityErr, frameErr,
            txState != ST_IDLE};
    end

endmodule

// ---- verif/scf_peer.sv ----
// Far-side serial peer: sends asynchronous frames and makes the bit tick.
// Assumes one bit lasts BIT_CYC clocks; the idle line is pulled high.
`timescale 1ns/1ps
module scf_peer #(
    parameter int BIT_CYC = 25
) (
    input wire logic clk,
    input wire logic go,
    input wire logic [12:0] frame,
    input wire logic [3:0] len,
    output logic rxd = 1'b1,
    output logic tick
);
    int phase = 0;
    int left = 0;
    logic [12:0] sh = '1;
    // Tick at mid-bit
    assign tick = (phase == BIT_CYC / 2);
    always @(posedge clk) begin
        phase <= (phase == BIT_CYC - 1) ? 0 : phase + 1;
        if (go) begin
            sh <= frame;
            left <= len;
        end else if (phase == BIT_CYC - 1) begin
            rxd <= (left > 0) ? sh[0] : 1'b1;
            sh <= sh >> 1;
            left <= (left > 0) ? left - 1 : 0;
        end
    end
endmodule

// ---- verif/scf_top_asserts.sv ----
// Checker for the setting registers and the channel 0 frame engine.
// Assumes it is bound to scf_top and sees only its ports.
`timescale 1ns/1ps
module scf_top_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [scf_pkg::ADDR_W-1:0] memAddr,
    input wire logic [15:0] memWdata,
    input wire logic memWrite,
    input wire logic memRead,
    input wire logic [15:0] memRdata,
    input wire scf_pkg::scf_chan_in_s [scf_pkg::CH_NUM-1:0] chanIn,
    input wire logic [scf_pkg::CH_NUM-1:0] serialClockPin,
    input wire logic [scf_pkg::CH_NUM-1:0] rxdPin,
    input wire scf_pkg::scf_chan_out_s [scf_pkg::CH_NUM-1:0] chanOut
);
    import scf_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_rd(a);
        memRead && memAddr == a;
    endsequence
    sequence s_two_wire;
        chanIn[0].modeHigh ##1 chanIn[0].modeHigh;
    endsequence
    chk_fixed_bits: assert property ((s_rd(ADDR_SET_CH0) or s_rd(ADDR_SET_CH1)) |=>
        memRdata[2] && !memRdata[11] && !memRdata[6] && !memRdata[3]) else $error("fixed bits wrong");
    chk_ch1_stop: assert property (s_rd(ADDR_SET_CH1) |=> !memRdata[5]) else $error("ch1 bit 5 set");
    chk_err_steer: assert property (chanOut[0].rxErrIrq |->
        (chanOut[0].parityErr || chanOut[0].frameErr) && !chanOut[0].rxDoneIrq) else $error("error steering");
    chk_start_bit: assert property ($rose(chanOut[0].txBusy) && chanIn[0].modeLow |->
        chanOut[0].txd == LINE_START) else $error("no start bit");
    chk_stop_irq: assert property (chanOut[0].xferIrq && !chanIn[0].irqSource |->
        chanOut[0].txd && !chanOut[0].txBusy) else $error("transfer end early");
    chk_empty_irq: assert property (chanOut[0].xferIrq && chanIn[0].irqSource |->
        $past(chanIn[0].txLoad) || $past(chanIn[0].txLoad, 2)) else $error("buffer empty irq without load");
    chk_tx_abort: assert property (!chanIn[0].running |=> !chanOut[0].txBusy && chanOut[0].txd)
        else $error("stopped channel busy");
    chk_two_wire: assert property (s_two_wire |-> !chanOut[0].txBusy) else $error("engine active");
endmodule
bind scf_top scf_top_asserts scf_top_asserts_i (.clk(clk), .rst_b(rst_b), .memAddr(memAddr),
    .memWdata(memWdata), .memWrite(memWrite), .memRead(memRead), .memRdata(memRdata), .chanIn(chanIn),
    .serialClockPin(serialClockPin), .rxdPin(rxdPin), .chanOut(chanOut));

// ---- verif/tb.sv ----
// Bench: register table, frames both ways, clocked receive, reset.
// Assumes scf_peer supplies the receive line of channel 0 and the bit tick.
`timescale 1ns/1ps
module tb;
    import scf_pkg::*;
    typedef struct packed {logic [19:0] a; logic [15:0] w; logic [15:0] e;} scf_row_s;
    localparam logic [8:0] TX_WORD = 9'h1A6;
    localparam logic [7:0] CLK_WORD = 8'hC9;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] memAddr = '0;
    logic [15:0] memWdata = '0;
    logic memWrite = 1'b0;
    logic memRead = 1'b0;
    logic [15:0] memRdata;
    scf_chan_in_s [CH_NUM-1:0] chanIn = '0;
    scf_chan_in_s [CH_NUM-1:0] chanTo;
    scf_chan_out_s [CH_NUM-1:0] chanOut;
    logic go = 1'b0;
    logic [12:0] pf = '1;
    logic [3:0] pl = '0;
    logic rxd0, tick;
    logic sclk1 = 1'b0;
    logic sd1 = 1'b1;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    int irqAt = 0;
    scf_row_s rows [6] = '{'{ADDR_SET_CH0, 16'hFFFF, 16'hF7B7}, '{ADDR_SET_CH1, 16'hFFFF, 16'hF797},
        '{ADDR_SET_CH0, 16'h0000, 16'h0004}, '{ADDR_SET_CH1, 16'h0000, 16'h0004},
        '{ADDR_SET_CH0, 16'hA5A5, 16'hA5A5}, '{20'hF011C, 16'hFFFF, 16'h0000}};
    scf_top scf_top_i (.clk(clk), .rst_b(rst_b), .memAddr(memAddr), .memWdata(memWdata), .memWrite(memWrite),
        .memRead(memRead), .memRdata(memRdata), .chanIn(chanTo), .serialClockPin({sclk1, 1'b0}),
        .rxdPin({sd1, rxd0}), .chanOut(chanOut));
    scf_peer scf_peer_i (.clk(clk), .go(go), .frame(pf), .len(pl), .rxd(rxd0), .tick(tick));
    initial begin
        forever #2.5 clk = ~clk;
    end
    always_comb begin
        chanTo = chanIn;
        chanTo[0].bitTick = tick;
        chanTo[1].bitTick = tick;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (chanOut[0].xferIrq === 1'b1) irqAt <= cycles;
        if (cycles == 10000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp1(input string what, input logic exp, input logic got);
        cmp16(what, {15'h0, exp}, {15'h0, got});
    endtask
    task automatic wr(input logic [19:0] a, input logic [15:0] d);
        @(posedge clk);
        memAddr <= a;
        memWdata <= d;
        memWrite <= 1'b1;
        @(posedge clk);
        memWrite <= 1'b0;
    endtask
    task automatic chkreg(input logic [19:0] a, input logic [15:0] e);
        @(posedge clk);
        memAddr <= a;
        memRead <= 1'b1;
        @(posedge clk);
        memRead <= 1'b0;
        #1 cmp16("setting word", e, memRdata);
    endtask
    task automatic setcfg(input logic [15:0] cfg);
        chanIn[0].running <= 1'b0;
        wr(ADDR_SET_CH0, cfg);
        chanIn[0].running <= 1'b1;
    endtask
    function automatic logic [15:0] cfgw(input logic tx, input logic rx, input logic eoc, input logic [1:0] par,
        input logic lsb, input logic [1:0] st, input logic [1:0] len);
        cfgw = {tx, rx, 3'h0, eoc, par, lsb, 1'b0, st, 1'b0, 1'b1, len};
    endfunction
    function automatic logic [12:0] mkframe(input logic [8:0] d, input int n, input logic lsb,
        input logic [1:0] par, input int st, output int len);
        logic p;
        mkframe = '1;
        mkframe[0] = LINE_START;
        p = 1'b0;
        len = 1;
        for (int i = 0; i < n; i++) begin
            mkframe[len] = lsb ? d[i] : d[n - 1 - i];
            p ^= d[i];
            len++;
        end
        if (par != PAR_NONE) begin
            mkframe[len] = (par == PAR_EVEN) ? p : (par == PAR_ODD) ? !p : 1'b0;
            len++;
        end
        len += st;
    endfunction
    task automatic txcase(input logic [15:0] cfg, input int n, input logic lsb, input logic [1:0] par,
        input int st, input logic irq);
        logic [12:0] f, got;
        int len, t0, t1;
        f = mkframe(TX_WORD, n, lsb, par, st, len);
        got = '1;
        chanIn[0].irqSource <= irq;
        setcfg(cfg);
        chanIn[0].txData <= TX_WORD;
        chanIn[0].txLoad <= 1'b1;
        @(posedge clk);
        t0 = cycles;
        chanIn[0].txLoad <= 1'b0;
        #1 got[0] = chanOut[0].txd;
        for (int i = 1; i <= len; i++) begin
            do @(posedge clk); while (tick !== 1'b1);
            t1 = cycles;
            #1 if (i < len) got[i] = chanOut[0].txd;
        end
        repeat (8) @(posedge clk);
        cmp16("tx frame", {3'h0, f}, {3'h0, got});
        cmp16("xfer irq delay", irq ? 16'h0001 : 16'h0002, 16'(irqAt - (irq ? t0 : t1)));
    endtask
    task automatic rxcase(input logic [15:0] cfg, input int n, input logic lsb, input logic [1:0] par,
        input logic [12:0] xm, input logic [3:0] ex);
        logic [12:0] f;
        logic [3:0] seen;
        int len;
        f = mkframe(9'h0B5, n, lsb, par, 1, len) ^ xm;
        seen = '0;
        setcfg(cfg);
        pf <= f;
        pl <= 4'(len);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (400) begin
            @(posedge clk);
            #1 seen |= {chanOut[0].rxDoneIrq, chanOut[0].rxErrIrq, chanOut[0].parityErr, chanOut[0].frameErr};
        end
        cmp16("rx flags", {12'h0, ex}, {12'h0, seen});
        cmp16("rx word", {7'h0, 9'h0B5 & ~(9'h1FF << n)}, {7'h0, chanOut[0].rxWord});
    endtask
    task automatic notx(input logic [15:0] cfg, input logic tw);
        chanIn[0].modeHigh <= tw;
        chanIn[0].modeLow <= !tw;
        setcfg(cfg);
        chanIn[0].txLoad <= 1'b1;
        @(posedge clk);
        chanIn[0].txLoad <= 1'b0;
        repeat (3) @(posedge clk);
        #1 cmp1("tx idle", 1'b1, chanOut[0].txd);
    endtask
    initial begin
        chanIn[0].modeLow <= 1'b1;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        chkreg(ADDR_SET_CH0, SET_RESET);
        chkreg(ADDR_SET_CH1, SET_RESET);
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].w);
            chkreg(rows[k].a, rows[k].e);
        end
        chkreg(ADDR_SET_CH0, 16'hA5A5);
        setcfg(16'hC2A6);
        wr(ADDR_SET_CH0, 16'h0000);
        chkreg(ADDR_SET_CH0, 16'hC2A6);
        txcase(cfgw(1'b1, 1'b0, 1'b0, PAR_NONE, 1'b0, STOP_ONE, LEN_8), 8, 1'b0, PAR_NONE, 1, 1'b0);
        txcase(cfgw(1'b1, 1'b0, 1'b0, PAR_ZERO, 1'b1, STOP_TWO, LEN_7), 7, 1'b1, PAR_ZERO, 2, 1'b0);
        txcase(cfgw(1'b1, 1'b0, 1'b0, PAR_EVEN, 1'b1, STOP_ONE, LEN_9), 9, 1'b1, PAR_EVEN, 1, 1'b0);
        txcase(cfgw(1'b1, 1'b0, 1'b0, PAR_ODD, 1'b0, STOP_NONE, LEN_8), 8, 1'b0, PAR_ODD, 0, 1'b0);
        txcase(cfgw(1'b1, 1'b1, 1'b0, PAR_NONE, 1'b0, STOP_ONE, LEN_8), 8, 1'b0, PAR_NONE, 1, 1'b1);
        chanIn[0].irqSource <= 1'b0;
        rxcase(cfgw(1'b0, 1'b1, 1'b1, PAR_EVEN, 1'b0, STOP_ONE, LEN_8), 8, 1'b0, PAR_EVEN, 13'h0, 4'h8);
        rxcase(cfgw(1'b0, 1'b1, 1'b1, PAR_ODD, 1'b0, STOP_ONE, LEN_8), 8, 1'b0, PAR_ODD, 13'h200, 4'h6);
        rxcase(cfgw(1'b0, 1'b1, 1'b0, PAR_EVEN, 1'b0, STOP_ONE, LEN_8), 8, 1'b0, PAR_EVEN, 13'h200, 4'hA);
        rxcase(cfgw(1'b0, 1'b1, 1'b0, PAR_ZERO, 1'b1, STOP_ONE, LEN_7), 7, 1'b1, PAR_ZERO, 13'h100, 4'h8);
        rxcase(cfgw(1'b0, 1'b1, 1'b0, PAR_NONE, 1'b0, STOP_ONE, LEN_8), 8, 1'b0, PAR_NONE, 13'h200, 4'h9);
        notx(cfgw(1'b0, 1'b1, 1'b0, PAR_NONE, 1'b0, STOP_ONE, LEN_8), 1'b0);
        notx(cfgw(1'b1, 1'b1, 1'b0, PAR_NONE, 1'b0, STOP_ONE, LEN_8), 1'b1);
        wr(ADDR_SET_CH1, cfgw(1'b0, 1'b1, 1'b0, PAR_NONE, 1'b0, STOP_NONE, LEN_8));
        chanIn[1].running <= 1'b1;
        #1.3;
        for (int i = 7; i >= 0; i--) begin
            sd1 = CLK_WORD[i];
            #62.5 sclk1 = 1'b1;
            #62.5 sclk1 = 1'b0;
        end
        sd1 = ~sd1;
        repeat (10) @(posedge clk);
        cmp16("clocked word", {8'h0, CLK_WORD}, {7'h0, chanOut[1].rxWord});
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        chkreg(ADDR_SET_CH0, SET_RESET);
        give_verdict();
    end
endmodule
